// ---- bench/lmc_config_regs_assertions.sv ----
`timescale 1ns/1ps
// Port-level checks of the configuration register block
module lmc_config_regs_assertions
  import lmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_reg,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        rsp_valid,
  input  lmc_status_t      rsp_status,
  input  wire logic [15:0] rsp_data,
  input  wire logic        cmd_error,
  input  wire logic        hw_output_disable_n,
  input  wire logic        software_output_enable,
  input  wire logic [15:0] fatal_status_reg,
  input  wire logic        tune_start,
  input  wire logic        fatal_line_n,
  input  wire logic        output_disable,
  input  wire logic        tune_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Tune end: one-cycle done pulse on the third edge after the start
  sequence s_tune_end;
    ##3 tune_done ##1 !tune_done;
  endsequence

  a_rsp_one_cycle: assert property (cmd_valid |=> rsp_valid)
    else $error("no response after command");
  a_rsp_not_stray: assert property (!cmd_valid |=> !rsp_valid)
    else $error("response without command");
  a_err_zero_data: assert property (cmd_error |-> rsp_valid && rsp_data == 16'h0000)
    else $error("failed command returned data");
  a_bad_reg_refused: assert property (cmd_valid && (cmd_reg < 8'h33 || cmd_reg > 8'h36)
    |=> cmd_error && rsp_status == LMC_ST_EXEC_ERR) else $error("unmapped register accepted");
  a_grid_write_refused: assert property (cmd_valid && cmd_write && cmd_reg == 8'h34
    && !output_disable |=> cmd_error) else $error("grid write accepted while enabled");
  a_write_echo: assert property (cmd_valid && cmd_write && cmd_reg == 8'h35
    |=> rsp_data == $past(cmd_wdata)) else $error("write not echoed");
  a_tune_walk: assert property (tune_start |-> s_tune_end)
    else $error("tune done pulse misplaced");
  a_sw_disable: assert property (!software_output_enable |=> output_disable)
    else $error("output on without software enable");
  a_hw_disable: assert property (!hw_output_disable_n [*4] |=> output_disable)
    else $error("output on with disable pin low");
  a_fatal_low: assert property (|fatal_status_reg[10:8] |=> !fatal_line_n)
    else $error("fatal line not driven low");
endmodule : lmc_config_regs_assertions

// ---- bench/lmc_config_regs_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module lmc_config_regs_tb
  import lmc_pkg::*;
;
  logic        clk, rst, cmd_valid, cmd_write, rsp_valid, cmd_error, tune_start, tune_done;
  logic        iface_select0, iface_select1, hw_output_disable_n, software_output_enable;
  logic        cmd_exec_fail, cmd_comm_fail, cmd_pending, latch_clear, alarm_line_n, v;
  logic        fatal_line_n, service_request_n, output_disable;
  logic        execution_error_latch, comm_error_latch, nv_load;
  logic [1:0]  srq_enable;
  logic [7:0]  cmd_reg;
  logic [15:0] cmd_wdata, rsp_data, fatal_status_reg, fatal_trigger_mask, tune_channel;
  logic [15:0] freq_thz, freq_fine, q, ft, ff;
  lmc_status_t rsp_status, st;
  int          bad_count, checked, n;

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Block under test and the host on its command port
  lmc_config_regs i_lmc_config_regs (.clk, .rst, .cmd_valid, .cmd_write, .cmd_reg,
    .cmd_wdata, .rsp_valid, .rsp_status, .rsp_data, .cmd_error, .nv_load(nv_load),
    .nv_config(16'h0000), .nv_grid(16'h0064), .nv_fcf_thz(16'h0000), .nv_fcf_fine(16'h0000),
    .iface_select0, .iface_select1, .hw_output_disable_n, .software_output_enable,
    .fatal_status_reg, .fatal_trigger_mask, .tune_start, .tune_channel, .cmd_exec_fail,
    .cmd_comm_fail, .cmd_pending, .latch_clear, .srq_enable, .alarm_line_n, .fatal_line_n,
    .service_request_n, .output_disable, .execution_error_latch, .comm_error_latch,
    .tune_done, .freq_thz, .freq_fine);
  lmc_host_model i_lmc_host_model (.clk, .cmd_valid, .cmd_write, .cmd_reg, .cmd_wdata,
    .rsp_valid, .rsp_status, .rsp_data);

  // One command and its answer
  task automatic cmd(input logic w, input logic [7:0] r, input logic [15:0] d,
                     input lmc_status_t es, input logic [15:0] eq);
    i_lmc_host_model.xfer(w, r, d, v, st, q);
    `CHK(v, 1'b1)
    `CHK(st, es)
    `CHK(q, eq)
  endtask : cmd

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Reset contents with both strap pins low
  task automatic t_defaults;
    cmd(1'b0, 8'h33, 16'h0000, LMC_ST_OK, 16'h0012);
    cmd(1'b0, 8'h34, 16'h0000, LMC_ST_OK, 16'h01f4);
    cmd(1'b0, 8'h35, 16'h0000, LMC_ST_OK, 16'h00c2);
    cmd(1'b0, 8'h36, 16'h0000, LMC_ST_OK, 16'h06d6);
  endtask : t_defaults

  // Undefined configuration bits stay zero
  task automatic t_mcb;
    cmd(1'b1, 8'h33, 16'hffff, LMC_ST_OK, 16'h0016);
    cmd(1'b0, 8'h33, 16'h0000, LMC_ST_OK, 16'h0016);
  endtask : t_mcb

  // Grid write with output on, unmapped read, latch and service request
  task automatic t_refuse;
    software_output_enable <= 1'b1;
    repeat (2) @(posedge clk);
    cmd(1'b1, 8'h34, 16'h0032, LMC_ST_EXEC_ERR, 16'h0000);
    repeat (2) @(posedge clk);
    `CHK(execution_error_latch, 1'b1)
    `CHK(service_request_n, 1'b0)
    cmd(1'b0, 8'h34, 16'h0000, LMC_ST_OK, 16'h01f4);
    cmd(1'b0, 8'h40, 16'h0000, LMC_ST_EXEC_ERR, 16'h0000);
    latch_clear <= 1'b1;
    @(posedge clk);
    latch_clear <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(execution_error_latch, 1'b0)
  endtask : t_refuse

  // Negative grid stored, used only at the next tune
  task automatic t_tune;
    software_output_enable <= 1'b0;
    repeat (2) @(posedge clk);
    ft = freq_thz;
    ff = freq_fine;
    cmd(1'b1, 8'h34, 16'hffce, LMC_ST_OK, 16'hffce);
    `CHK({freq_thz, freq_fine}, {ft, ff})
    software_output_enable <= 1'b1;
    tune_channel <= 16'h0003;
    repeat (3) @(posedge clk);
    tune_start <= 1'b1;
    @(posedge clk);
    tune_start <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(alarm_line_n, 1'b0)
    for (n = 0; n < 8 && tune_done !== 1'b1; n++) @(posedge clk);
    `CHK(tune_done, 1'b1)
    if (tune_done !== 1'b1) close_out();
    @(posedge clk);
    `CHK(alarm_line_n, 1'b1)
    `CHK({freq_thz, freq_fine}, {16'h00c2, 16'h0672})
  endtask : t_tune

  // Masked fatal with shutdown set, then output and alarm
  task automatic t_fatal;
    fatal_status_reg   <= 16'h0200;
    fatal_trigger_mask <= 16'h0200;
    repeat (3) @(posedge clk);
    `CHK(fatal_line_n, 1'b0)
    `CHK(output_disable, 1'b1)
    `CHK(alarm_line_n, 1'b0)
    fatal_status_reg <= 16'h0000;
    repeat (3) @(posedge clk);
    `CHK(output_disable, 1'b0)
  endtask : t_fatal

  // Second reset with the first strap pin high
  task automatic t_strap;
    rst           <= 1'b1;
    iface_select0 <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmd(1'b0, 8'h33, 16'h0000, LMC_ST_OK, 16'h0002);
  endtask : t_strap

  // Latches with error flags off, pending failure, disable pin, stored image
  task automatic t_latch;
    cmd_comm_fail <= 1'b1;
    cmd_exec_fail <= 1'b1;
    @(posedge clk);
    cmd_comm_fail <= 1'b0;
    cmd_exec_fail <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(comm_error_latch, 1'b0)
    `CHK(execution_error_latch, 1'b0)
    cmd_pending   <= 1'b1;
    cmd_exec_fail <= 1'b1;
    @(posedge clk);
    cmd_pending   <= 1'b0;
    cmd_exec_fail <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(execution_error_latch, 1'b1)
    `CHK(service_request_n, 1'b0)
    hw_output_disable_n <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(output_disable, 1'b1)
    hw_output_disable_n <= 1'b1;
    nv_load <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    cmd(1'b0, 8'h34, 16'h0000, LMC_ST_OK, 16'h0064);
  endtask : t_latch

  // Main sequence
  initial begin
    {rst, srq_enable, hw_output_disable_n} = 4'hf;
    {iface_select0, iface_select1, software_output_enable, tune_start} = 4'h0;
    {cmd_exec_fail, cmd_comm_fail, cmd_pending, latch_clear} = 4'h0;
    fatal_status_reg   = 16'h0000;
    fatal_trigger_mask = 16'h0000;
    tune_channel       = 16'h0001;
    nv_load            = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_defaults();
    t_mcb();
    t_refuse();
    t_tune();
    t_fatal();
    t_strap();
    t_latch();
    close_out();
  end
endmodule : lmc_config_regs_tb

bind lmc_config_regs lmc_config_regs_assertions i_lmc_config_regs_assertions (.clk, .rst,
  .cmd_valid, .cmd_write, .cmd_reg, .cmd_wdata, .rsp_valid, .rsp_status, .rsp_data,
  .cmd_error, .hw_output_disable_n, .software_output_enable, .fatal_status_reg,
  .tune_start, .fatal_line_n, .output_disable, .tune_done);

// ---- bench/lmc_host_model.sv ----
`timescale 1ns/1ps
// Host controller on the command port: one command, answer on the next edge
module lmc_host_model
  import lmc_pkg::*;
(
  input  wire logic        clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_reg,
  output logic [15:0]      cmd_wdata,
  input  wire logic        rsp_valid,
  input  lmc_status_t      rsp_status,
  input  wire logic [15:0] rsp_data
);
  // Idle command port
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_reg   = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Drive after an edge, release at the taking edge, read the answer one edge on
  task automatic xfer(input logic w, input logic [7:0] r, input logic [15:0] d,
                      output logic v, output lmc_status_t st, output logic [15:0] q);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_reg   <= r;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d; // Released data does not keep the last value
    @(posedge clk);
    v  = rsp_valid;
    st = rsp_status;
    q  = rsp_data;
  endtask : xfer
endmodule : lmc_host_model

// ---- hdl/lmc_config_regs.sv ----
`timescale 1ns/1ps
// Operation
// - With alarm_during_tuning set, alarm low during tune and while output disabled.
// - Tuning alarm released as soon as a tune completes.
// - alarm_during_tuning resets to 1.
// - With shutdown_on_fatal set, output disabled during masked fatal; bit resets to 0.
// - Fatal present when any fatal status bit 10..8 is set.
// - Fatal condition drives the active-low fatal line low.
// - error_flag_assert 1 sets both error latches for the current command.
// - error_flag_assert 0: never comm latch; exec latch only for failing pending commands.
// - Pending command ending in execution error always sets exec latch.
// - Service request asserted when an enabled latch flag becomes set.
// - error_flag_assert default from iface_select0 alone, inverted, caught at reset.
// - Registers non-volatile; defaults replaced by a stored configuration.
// - Grid spacing write with output enabled rejected as execution error.
// - Stored grid spacing used only at the next tune.
// - Frequency = (channel-1)*grid/10 + first-channel frequency, in GHz.
// - Grid spacing signed 16 bits in 0.1 GHz units.
// - Any grid spacing value accepted.
// - First-channel frequency: THz word and 0.1 GHz word, unsigned.
// - Output off on masked fatal with shutdown, software disable, or hardware disable.
`include "lmc_defines.svh"
module lmc_config_regs
  import lmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // Command port from the serial interface decoder
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_reg,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output lmc_status_t      rsp_status,
  output logic [15:0]      rsp_data,
  output logic             cmd_error,
  // Stored configuration image load
  input  wire logic        nv_load,
  input  wire logic [15:0] nv_config,
  input  wire logic [15:0] nv_grid,
  input  wire logic [15:0] nv_fcf_thz,
  input  wire logic [15:0] nv_fcf_fine,
  // Pins
  input  wire logic        iface_select0,
  input  wire logic        iface_select1,
  input  wire logic        hw_output_disable_n,
  // Device state
  input  wire logic        software_output_enable,
  input  wire logic [15:0] fatal_status_reg,
  input  wire logic [15:0] fatal_trigger_mask,
  input  wire logic        tune_start,
  input  wire logic [15:0] tune_channel,
  input  wire logic        cmd_exec_fail,
  input  wire logic        cmd_comm_fail,
  input  wire logic        cmd_pending,
  input  wire logic        latch_clear,
  input  wire logic [1:0]  srq_enable,
  // Outputs
  output logic             alarm_line_n,
  output logic             fatal_line_n,
  output logic             service_request_n,
  output logic             output_disable,
  output logic             execution_error_latch,
  output logic             comm_error_latch,
  output logic             tune_done,
  output logic [15:0]      freq_thz,
  output logic [15:0]      freq_fine
);

  logic              sel0_s;
  logic              sel1_s;
  logic              dis_n_s;
  logic              strap_pend;
  logic [2:0]        strap_wait;
  logic [15:0]       module_behaviour_config;
  logic [15:0]       channel_grid_spacing;
  logic [15:0]       first_channel_freq_thz;
  logic [15:0]       first_channel_freq_fine;
  logic              alarm_during_tuning;
  logic              shutdown_on_fatal;
  logic              error_flag_assert;
  logic              fatal_now;
  logic              disable_now;
  logic              tuning;
  lmc_tune_t         tune_state;
  logic signed [31:0] calc_ghz10;
  logic signed [31:0] next_ghz10;
  logic [31:0]       ghz10_u;
  logic              wr_ok;
  logic              rd_ok;
  logic              grid_block;
  logic [15:0]       rd_mux;
  logic              set_xel;
  logic              set_cel;

  // Pin synchronisers
  lmc_sync2 u_sync_sel0 (.clk(clk), .rst(rst), .din(iface_select0),       .dout(sel0_s));
  lmc_sync2 u_sync_sel1 (.clk(clk), .rst(rst), .din(iface_select1),       .dout(sel1_s));
  lmc_sync2 u_sync_dis  (.clk(clk), .rst(rst), .din(hw_output_disable_n), .dout(dis_n_s));

  // Behaviour fields of the configuration register
  assign alarm_during_tuning = module_behaviour_config[`LMC_BIT_ALARM_TUNE];
  assign shutdown_on_fatal   = module_behaviour_config[`LMC_BIT_SHUTDOWN];
  assign error_flag_assert   = module_behaviour_config[`LMC_BIT_ERR_FLAG];

  // Fatal and output disable terms
  assign fatal_now   = |fatal_status_reg[`LMC_FATAL_HI:`LMC_FATAL_LO];
  assign disable_now = (|(fatal_status_reg & fatal_trigger_mask) && shutdown_on_fatal && fatal_now)
                       || !software_output_enable || !dis_n_s;

  // Command decode
  assign grid_block = (cmd_reg == `LMC_REG_GRID) && !output_disable;
  assign wr_ok = cmd_valid && cmd_write && !grid_block &&
                 (cmd_reg == `LMC_REG_CONFIG || cmd_reg == `LMC_REG_GRID ||
                  cmd_reg == `LMC_REG_FCF_THZ || cmd_reg == `LMC_REG_FCF_FINE);
  assign rd_ok = cmd_valid && !cmd_write &&
                 (cmd_reg == `LMC_REG_CONFIG || cmd_reg == `LMC_REG_GRID ||
                  cmd_reg == `LMC_REG_FCF_THZ || cmd_reg == `LMC_REG_FCF_FINE);

  // Read data select
  always_comb begin
    unique case (cmd_reg)
      `LMC_REG_CONFIG:   rd_mux = module_behaviour_config;
      `LMC_REG_GRID:     rd_mux = channel_grid_spacing;
      `LMC_REG_FCF_THZ:  rd_mux = first_channel_freq_thz;
      `LMC_REG_FCF_FINE: rd_mux = first_channel_freq_fine;
      default:           rd_mux = 16'h0000;
    endcase
  end

  // Strap capture window: three cycles after release, so the last capture
  // sees the pin through both synchroniser stages, not their reset value
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_wait <= 3'b111;
    end else begin
      strap_wait <= {strap_wait[1:0], 1'b0};
    end
  end

  assign strap_pend = strap_wait[2];

  // Behaviour configuration register
  always_ff @(posedge clk) begin
    if (rst) begin
      module_behaviour_config <= 16'h0002;
    end else if (strap_pend) begin
      module_behaviour_config <= 16'h0002 | {11'h000, ~sel0_s, 4'h0};
    end else if (nv_load) begin
      module_behaviour_config <= nv_config & `LMC_CONFIG_MASK;
    end else if (wr_ok && cmd_reg == `LMC_REG_CONFIG) begin
      module_behaviour_config <= cmd_wdata & `LMC_CONFIG_MASK;
    end
  end

  // Grid and first-channel frequency registers
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_grid_spacing    <= `LMC_RST_GRID;
      first_channel_freq_thz  <= `LMC_RST_FCF_THZ;
      first_channel_freq_fine <= `LMC_RST_FCF_FINE;
    end else if (nv_load) begin
      channel_grid_spacing    <= nv_grid;
      first_channel_freq_thz  <= nv_fcf_thz;
      first_channel_freq_fine <= nv_fcf_fine;
    end else if (wr_ok) begin
      if (cmd_reg == `LMC_REG_GRID) begin
        channel_grid_spacing <= cmd_wdata;
      end
      if (cmd_reg == `LMC_REG_FCF_THZ) begin
        first_channel_freq_thz <= cmd_wdata;
      end
      if (cmd_reg == `LMC_REG_FCF_FINE) begin
        first_channel_freq_fine <= cmd_wdata;
      end
    end
  end

  // Command response
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid  <= 1'b0;
      rsp_status <= LMC_ST_OK;
      rsp_data   <= 16'h0000;
      cmd_error  <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
      cmd_error <= cmd_valid && !(wr_ok || rd_ok);
      if (wr_ok) begin
        rsp_status <= LMC_ST_OK;
        rsp_data   <= (cmd_reg == `LMC_REG_CONFIG) ? (cmd_wdata & `LMC_CONFIG_MASK)
                                                   : cmd_wdata;
      end else if (rd_ok) begin
        rsp_status <= LMC_ST_OK;
        rsp_data   <= rd_mux;
      end else if (cmd_valid) begin
        rsp_status <= LMC_ST_EXEC_ERR;
        rsp_data   <= 16'h0000;
      end
    end
  end

  // Error latches, set wins over clear
  assign set_xel = (cmd_exec_fail && (cmd_pending || error_flag_assert))
                   || (cmd_valid && !(wr_ok || rd_ok) && error_flag_assert);
  assign set_cel = cmd_comm_fail && error_flag_assert;

  always_ff @(posedge clk) begin
    if (rst) begin
      execution_error_latch <= 1'b0;
      comm_error_latch      <= 1'b0;
    end else begin
      execution_error_latch <= set_xel || (execution_error_latch && !latch_clear);
      comm_error_latch      <= set_cel || (comm_error_latch && !latch_clear);
    end
  end

  // Service request on enabled latch
  always_ff @(posedge clk) begin
    if (rst) begin
      service_request_n <= 1'b1;
    end else begin
      service_request_n <= !((srq_enable[0] && (set_xel || (execution_error_latch && !latch_clear)))
                          || (srq_enable[1] && (set_cel || (comm_error_latch && !latch_clear))));
    end
  end

  // Tune sequencer: frequency computed from stored grid at tune time
  always_comb begin
    next_ghz10 = (32'(signed'({16'h0000, tune_channel})) - 32'sh1) * 32'(signed'(channel_grid_spacing))
               + 32'(signed'({16'h0000, first_channel_freq_thz})) * `LMC_GHZ_PER_THZ * `LMC_TENTHS
               + 32'(signed'({16'h0000, first_channel_freq_fine}));
  end

  assign ghz10_u = 32'(calc_ghz10);

  always_ff @(posedge clk) begin
    if (rst) begin
      tune_state <= LMC_TS_IDLE;
      calc_ghz10 <= 32'sh0;
      tuning     <= 1'b0;
      tune_done  <= 1'b0;
      freq_thz   <= 16'h0000;
      freq_fine  <= 16'h0000;
    end else begin
      tune_done <= 1'b0;
      unique case (tune_state)
        LMC_TS_IDLE: begin
          if (tune_start) begin
            calc_ghz10 <= next_ghz10;
            tuning     <= 1'b1;
            tune_state <= LMC_TS_CALC;
          end
        end
        LMC_TS_CALC: begin
          freq_thz   <= 16'(ghz10_u / 32'd10000);
          freq_fine  <= 16'(ghz10_u % 32'd10000);
          tune_state <= LMC_TS_DONE;
        end
        LMC_TS_DONE: begin
          tuning     <= 1'b0;
          tune_done  <= 1'b1;
          tune_state <= LMC_TS_IDLE;
        end
      endcase
    end
  end

  // Alarm, fatal and disable lines
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_line_n   <= 1'b1;
      fatal_line_n   <= 1'b1;
      output_disable <= 1'b1;
    end else begin
      alarm_line_n   <= !(alarm_during_tuning && (tuning || disable_now));
      fatal_line_n   <= !fatal_now;
      output_disable <= disable_now;
    end
  end

endmodule : lmc_config_regs

// ---- hdl/lmc_defines.svh ----
`ifndef LMC_DEFINES_SVH
`define LMC_DEFINES_SVH

// Register numbers on the command port
`define LMC_REG_CONFIG     8'h33
`define LMC_REG_GRID       8'h34
`define LMC_REG_FCF_THZ    8'h35
`define LMC_REG_FCF_FINE   8'h36

// Behaviour configuration fields
`define LMC_BIT_ALARM_TUNE 1
`define LMC_BIT_SHUTDOWN   2
`define LMC_BIT_ERR_FLAG   4
`define LMC_CONFIG_MASK    16'h0016

// Fatal status bits that mark a fatal condition
`define LMC_FATAL_HI       10
`define LMC_FATAL_LO       8

// Reset values of the non-volatile registers when no stored image is loaded
`define LMC_RST_GRID       16'h01f4
`define LMC_RST_FCF_THZ    16'h00c2
`define LMC_RST_FCF_FINE   16'h06d6

// Frequency arithmetic
`define LMC_GHZ_PER_THZ    32'sh000003e8
`define LMC_TENTHS         32'sh0000000a

`endif

// ---- hdl/lmc_pkg.sv ----
package lmc_pkg;
  typedef enum logic [1:0] {
    LMC_ST_OK,
    LMC_ST_EXEC_ERR
  } lmc_status_t;

  typedef enum logic [1:0] {
    LMC_TS_IDLE,
    LMC_TS_CALC,
    LMC_TS_DONE
  } lmc_tune_t;
endpackage : lmc_pkg

// ---- hdl/lmc_sync2.sv ----
`timescale 1ns/1ps
// Two flip-flop synchroniser for a pin level
module lmc_sync2 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  // First stage feeds the second and nothing else
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : lmc_sync2
